/* File: rtl/oms_fifo.v */
`timescale 1ns/1ps
`include "oms_regs.vh"

module oms_fifo #(
  parameter WIDTH = 65,
  parameter DEPTH = `OMS_FIFO_DEPTH,
  parameter AW = `OMS_FIFO_AW,
  parameter CW = `OMS_FIFO_CW
) (
  input wire ref_clk,
  input wire rst,
  input wire s_valid,
  output wire s_ready,
  input wire [WIDTH-1:0] s_data,
  output wire m_valid,
  input wire m_ready,
  output wire [WIDTH-1:0] m_data,
  output wire [CW-1:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg ready_reg;
  reg empty_reg;
  wire push;
  wire pop;

  // Flags are registered so ready and valid come straight from flops
  assign s_ready = ready_reg;
  assign m_valid = ~empty_reg;
  assign m_data = mem[rd_ptr_reg];
  assign level = count_reg;
  assign push = s_valid & ready_reg;
  assign pop = m_ready & ~empty_reg;

  always @* begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Storage and pointers; wrap relies on a power-of-two depth
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= s_data;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {CW{1'b0}};
      ready_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[CW-1:0]);
      empty_reg <= (count_next == {CW{1'b0}});
    end
  end

endmodule

/* File: rtl/oms_regs.vh */
`ifndef OMS_REGS_VH
`define OMS_REGS_VH

// Register byte addresses
`define OMS_ADDR_CTRL 8'h00
`define OMS_ADDR_GAIN_W1 8'h04
`define OMS_ADDR_GAIN_W2 8'h08
`define OMS_ADDR_STATUS 8'h0C

// Control register fields
`define OMS_CTRL_MODE1_LSB 0
`define OMS_CTRL_MODE1_MSB 2
`define OMS_CTRL_MODE2_LSB 4
`define OMS_CTRL_MODE2_MSB 6
`define OMS_CTRL_CARRIER_A_EN 8
`define OMS_CTRL_CARRIER_B_EN 9
`define OMS_CTRL_WIDTH 10
`define OMS_CTRL_RESET 10'h000

// Gain register fields, signed Q1.15
`define OMS_GAIN_FIRST_LSB 0
`define OMS_GAIN_FIRST_MSB 15
`define OMS_GAIN_SECOND_LSB 16
`define OMS_GAIN_SECOND_MSB 31
`define OMS_GAIN_RESET 32'h0000_7FFF

// Status register fields
`define OMS_STAT_SAT1 0
`define OMS_STAT_SAT2 1
`define OMS_STAT_LEVEL_LSB 4
`define OMS_STAT_LEVEL_MSB 7

// Modulation modes
`define OMS_MODE_OFF 3'h0
`define OMS_MODE_AA 3'h1
`define OMS_MODE_AB 3'h2
`define OMS_MODE_BA 3'h3
`define OMS_MODE_BB 3'h4
`define OMS_MODE_CALIB 3'h5

// Sample formats
`define OMS_SAMPLE_W 16
`define OMS_FRAC_BITS 15
`define OMS_FIFO_DEPTH 8
`define OMS_FIFO_AW 3
`define OMS_FIFO_CW 4
`define OMS_POS_FULL 20'sh07FFF
`define OMS_NEG_FULL 20'shF8000

`endif

/* File: rtl/oms_stage.v */
// Behaviour
// - Output one: gains times streams when off or on unsupported codes, chosen carriers per stream in the four carrier modes.
// - Output two: same structure with its own gains and independent mode.
// - Correction mode output one combines both carriers with both gains, cross-coupled.
// - Correction mode output two: same formula with output two gains.
// - Each further output pair uses another identical instance of this stage.
// - Dual play routes both streams to both outputs.
// - Correction mode sums four stream-carrier products weighted by gains.
// - Carriers arrive as cosine and sine and feed the carrier multipliers.
// - One dual stream core and one carrier pair feed each stage.
// - An enabled carrier (carrier_a on output one, carrier_b on output two) adds onto the output instead of replacing it.
`timescale 1ns/1ps
`include "oms_regs.vh"

// Self-contained per output pair; nothing is shared, so each pair is one more instance
module oms_stage (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire in_valid,
  output wire in_ready,
  input wire route_both,
  input wire [15:0] pattern_a,
  input wire [15:0] pattern_b,
  input wire [15:0] carrier_a,
  input wire [15:0] carrier_b,
  output reg out_valid,
  input wire dac_ready,
  output reg [15:0] wave_out1,
  output reg [15:0] wave_out2
);

  // Staged copies written by software, active copies used by the datapath
  reg [`OMS_CTRL_WIDTH-1:0] ctrl_reg;
  reg [31:0] gain_w1_reg;
  reg [31:0] gain_w2_reg;
  reg [`OMS_CTRL_WIDTH-1:0] act_ctrl_reg;
  reg [31:0] act_gain_w1_reg;
  reg [31:0] act_gain_w2_reg;
  reg sat1_reg;
  reg sat2_reg;
  wire [64:0] fifo_out;
  wire fifo_valid;
  wire [`OMS_FIFO_CW-1:0] fifo_level;
  wire take;
  wire access;
  wire setup_seen;
  wire [19:0] sum1;
  wire [19:0] sum2;
  wire carrier_a_en;
  wire carrier_b_en;

  ////////////////////////////////////////////////////////////
  // Arithmetic helpers
  // Q1.15 multiply, result kept in Q3.15 on 18 bits
  function signed [17:0] mul_q15;
    input signed [17:0] a;
    input signed [17:0] b;
    reg signed [35:0] p;
    begin
      p = a * b;
      mul_q15 = p[32:15];
    end
  endfunction

  function signed [17:0] ext;
    input [15:0] v;
    begin
      ext = {{2{v[15]}}, v};
    end
  endfunction

  // Carrier chosen by a mode bit: 0 picks carrier_a, 1 carrier_b
  function signed [17:0] pick;
    input sel;
    input [15:0] ca;
    input [15:0] cb;
    begin
      pick = sel ? ext(cb) : ext(ca);
    end
  endfunction

  // One output: off, four carrier modes, or imbalance correction
  function signed [19:0] out_calc;
    input [2:0] mode;
    input [15:0] g1;
    input [15:0] g2;
    input [15:0] pa;
    input [15:0] pb;
    input [15:0] ca;
    input [15:0] cb;
    reg signed [17:0] ta;
    reg signed [17:0] tb;
    reg signed [17:0] t3;
    reg signed [17:0] t4;
    begin
      ta = mul_q15(ext(g1), ext(pa));
      tb = mul_q15(ext(g2), ext(pb));
      t3 = 18'sh00000;
      t4 = 18'sh00000;
      case (mode)
        `OMS_MODE_AA, `OMS_MODE_AB, `OMS_MODE_BA, `OMS_MODE_BB: begin
          // Modes 1..4 encode first and second carrier index as bits of mode-1
          ta = mul_q15(ta, pick(mode == `OMS_MODE_BA || mode == `OMS_MODE_BB, ca, cb));
          tb = mul_q15(tb, pick(mode == `OMS_MODE_AB || mode == `OMS_MODE_BB, ca, cb));
        end
        `OMS_MODE_CALIB: begin
          // pa*(ca*g1 - cb*g2) + pb*(ca*g2 + cb*g1)
          ta = mul_q15(ext(pa), mul_q15(ext(ca), ext(g1)));
          t3 = -mul_q15(ext(pa), mul_q15(ext(cb), ext(g2)));
          tb = mul_q15(ext(pb), mul_q15(ext(ca), ext(g2)));
          t4 = mul_q15(ext(pb), mul_q15(ext(cb), ext(g1)));
        end
        default: begin
          // Off and unsupported codes: plain weighted sum
          ta = ta;
        end
      endcase
      out_calc = {{2{ta[17]}}, ta} + {{2{tb[17]}}, tb} + {{2{t3[17]}}, t3} + {{2{t4[17]}}, t4};
    end
  endfunction

  // Clamp to full scale rather than wrap
  function [15:0] sat16;
    input signed [19:0] v;
    begin
      if (v > `OMS_POS_FULL) begin
        sat16 = 16'h7FFF;
      end else if (v < `OMS_NEG_FULL) begin
        sat16 = 16'h8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // Same bounds as the clamp, feeding the sticky flags
  function is_sat;
    input signed [19:0] v;
    begin
      is_sat = (v > `OMS_POS_FULL) || (v < `OMS_NEG_FULL);
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Sample buffer: one word holds route flag, both streams and both carriers
  oms_fifo #(
    .WIDTH(65),
    .DEPTH(`OMS_FIFO_DEPTH),
    .AW(`OMS_FIFO_AW),
    .CW(`OMS_FIFO_CW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_valid(in_valid),
    .s_ready(in_ready),
    .s_data({route_both, pattern_a, pattern_b, carrier_a, carrier_b}),
    .m_valid(fifo_valid),
    .m_ready(take),
    .m_data(fifo_out),
    .level(fifo_level)
  );

  // Drain only when the output register is free, so a stalled DAC fills the FIFO
  assign take = fifo_valid & (~out_valid | dac_ready);

  wire [15:0] s_pa = fifo_out[63:48];
  wire [15:0] s_ca = fifo_out[31:16];
  wire [15:0] s_cb = fifo_out[15:0];
  // Without dual play each output sees only its own stream
  wire [15:0] pb_1 = fifo_out[64] ? fifo_out[47:32] : 16'h0000;
  wire [15:0] pa_2 = fifo_out[64] ? s_pa : 16'h0000;
  wire [15:0] s_pb = fifo_out[47:32];

  assign carrier_a_en = act_ctrl_reg[`OMS_CTRL_CARRIER_A_EN];
  assign carrier_b_en = act_ctrl_reg[`OMS_CTRL_CARRIER_B_EN];

  // Sum per output, with optional direct carrier added on top: carrier_a on output one, carrier_b on output two
  assign sum1 = out_calc(act_ctrl_reg[`OMS_CTRL_MODE1_MSB:`OMS_CTRL_MODE1_LSB],
                         act_gain_w1_reg[`OMS_GAIN_FIRST_MSB:`OMS_GAIN_FIRST_LSB],
                         act_gain_w1_reg[`OMS_GAIN_SECOND_MSB:`OMS_GAIN_SECOND_LSB],
                         s_pa, pb_1, s_ca, s_cb)
                + (carrier_a_en ? {{4{s_ca[15]}}, s_ca} : 20'h00000);
  assign sum2 = out_calc(act_ctrl_reg[`OMS_CTRL_MODE2_MSB:`OMS_CTRL_MODE2_LSB],
                         act_gain_w2_reg[`OMS_GAIN_FIRST_MSB:`OMS_GAIN_FIRST_LSB],
                         act_gain_w2_reg[`OMS_GAIN_SECOND_MSB:`OMS_GAIN_SECOND_LSB],
                         pa_2, s_pb, s_ca, s_cb)
                + (carrier_b_en ? {{4{s_cb[15]}}, s_cb} : 20'h00000);

  ////////////////////////////////////////////////////////////
  // Output register; one sample per accepted FIFO word
  // The pair holds while the DAC stalls, so no sample is torn
  always @(posedge ref_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      wave_out1 <= 16'h0000;
      wave_out2 <= 16'h0000;
    end else if (take) begin
      out_valid <= 1'b1;
      wave_out1 <= sat16(sum1);
      wave_out2 <= sat16(sum2);
    end else if (dac_ready) begin
      out_valid <= 1'b0;
    end
  end

  // Active settings follow the staged ones only in cycles in which no FIFO word is taken
  // Limitation: a take on every cycle holds off new settings until a gap appears
  always @(posedge ref_clk) begin
    if (rst) begin
      act_ctrl_reg <= `OMS_CTRL_RESET;
      act_gain_w1_reg <= `OMS_GAIN_RESET;
      act_gain_w2_reg <= `OMS_GAIN_RESET;
    end else if (~take) begin
      act_ctrl_reg <= ctrl_reg;
      act_gain_w1_reg <= gain_w1_reg;
      act_gain_w2_reg <= gain_w2_reg;
    end
  end

  ////////////////////////////////////////////////////////////
  // APB slave: one wait state, then the transfer completes
  // Unmapped or unaligned addresses answer with an error and read as zero
  assign setup_seen = psel & penable & ~pready;
  assign access = psel & penable & pready;

  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_seen;
      pslverr <= 1'b0;
      if (setup_seen) begin
        case (paddr)
          `OMS_ADDR_CTRL: prdata <= {22'h000000, ctrl_reg};
          `OMS_ADDR_GAIN_W1: prdata <= gain_w1_reg;
          `OMS_ADDR_GAIN_W2: prdata <= gain_w2_reg;
          `OMS_ADDR_STATUS: prdata <= {24'h000000, fifo_level, 2'b00, sat2_reg, sat1_reg};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Staged settings; a write lands on the completing edge only
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= `OMS_CTRL_RESET;
      gain_w1_reg <= `OMS_GAIN_RESET;
      gain_w2_reg <= `OMS_GAIN_RESET;
    end else if (access & pwrite) begin
      case (paddr)
        `OMS_ADDR_CTRL: ctrl_reg <= pwdata[`OMS_CTRL_WIDTH-1:0];
        `OMS_ADDR_GAIN_W1: gain_w1_reg <= pwdata;
        `OMS_ADDR_GAIN_W2: gain_w2_reg <= pwdata;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Sticky saturation flags, write one to clear; a new event beats the clear
  wire clr = access & pwrite & (paddr == `OMS_ADDR_STATUS);
  always @(posedge ref_clk) begin
    if (rst) begin
      sat1_reg <= 1'b0;
      sat2_reg <= 1'b0;
    end else begin
      if (take & is_sat(sum1)) begin
        sat1_reg <= 1'b1;
      end else if (clr & pwdata[`OMS_STAT_SAT1]) begin
        sat1_reg <= 1'b0;
      end
      if (take & is_sat(sum2)) begin
        sat2_reg <= 1'b1;
      end else if (clr & pwdata[`OMS_STAT_SAT2]) begin
        sat2_reg <= 1'b0;
      end
    end
  end

endmodule

/* File: verif/oms_dac_model.sv */
`timescale 1ns/1ps
module oms_dac_model (
  input logic ref_clk,
  input logic rst,
  input logic stall,
  input logic slow,
  input logic out_valid,
  output logic dac_ready,
  output int got
);
  logic tick;
  // Slow mode takes a pair every other cycle, so the stage must hold
  assign dac_ready = !stall && (!slow || tick);
  // Count accepted pairs; values are judged by the bench
  always @(posedge ref_clk) begin
    tick <= rst ? 1'b0 : !tick;
    if (rst) begin
      got <= 0;
    end else if (out_valid && dac_ready) begin
      got <= got + 1;
    end
  end
endmodule

/* File: verif/oms_stage_assertions.sv */
`timescale 1ns/1ps
module oms_chk (
  input logic ref_clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic in_valid,
  input logic in_ready,
  input logic out_valid,
  input logic dac_ready,
  input logic [15:0] wave_out1,
  input logic [15:0] wave_out2
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Bus answers after one wait state, as a single pulse
  wait_one_a: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  pulse_only_a: assert property (pready |=> !pready) else $error("long answer");
  setup_quiet_a: assert property (psel && !penable |=> !pready) else $error("early answer");
  // Refused places flag an error and read as zero
  map_error_a: assert property (pready && paddr > 8'h0C |-> pslverr && prdata == 0) else $error("no refusal");
  map_ok_a: assert property (pready && paddr[1:0] == 0 && paddr <= 8'h0C |-> !pslverr) else $error("bad refusal");
  // A pair stands until taken, so no sample is torn
  hold_pair_a: assert property (out_valid && !dac_ready |=> out_valid &&
    $stable(wave_out1) && $stable(wave_out2)) else $error("pair changed");
  drop_taken_a: assert property ($fell(out_valid) |-> $past(dac_ready)) else $error("pair lost");
  full_cause_a: assert property ($fell(in_ready) |-> $past(in_valid)) else $error("false full");
  reset_idle_a: assert property (disable iff (1'b0) rst |=>
    !out_valid && !pready && in_ready) else $error("reset state");
  cover property (pready && pslverr);
  cover property (out_valid && !dac_ready);
  cover property (!in_ready);
endmodule
bind oms_stage oms_chk chk (.ref_clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .in_valid,
  .in_ready, .out_valid, .dac_ready, .wave_out1, .wave_out2);

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "oms_regs.vh"
module tb;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, in_valid = 0, route_both = 1, stall = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, ctrl, gw1, gw2, prdata;
  logic [15:0] pattern_a = 16'h0, pattern_b = 16'h0, carrier_a = 16'h0, carrier_b = 16'h0, wave_out1, wave_out2;
  logic pready, pslverr, in_ready, out_valid, dac_ready, serr;
  int err_count = 0, tests_run = 0, sent = 0, got, n;
  logic [31:0] eq[$];
  oms_stage uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_ready, .route_both, .pattern_a, .pattern_b, .carrier_a, .carrier_b, .out_valid,
    .dac_ready, .wave_out1, .wave_out2);
  oms_dac_model dac (.ref_clk, .rst, .stall, .slow, .out_valid, .dac_ready, .got);
  initial forever #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  function automatic int t(int x, int y);
    return (x * y) >>> 15;
  endfunction
  // Reference output, each product truncated as the stage does
  function automatic logic [15:0] wv(logic [2:0] m, logic [31:0] g, int a, int b, int c1, int c2, int ad);
    int g1, g2, x, y, v;
    g1 = $signed(g[15:0]);
    g2 = $signed(g[31:16]);
    x = (m == 3 || m == 4) ? c2 : c1;
    y = (m == 2 || m == 4) ? c2 : c1;
    if (m == 5) v = t(a, t(c1, g1)) - t(a, t(c2, g2)) + t(b, t(c1, g2)) + t(b, t(c2, g1));
    else if (m >= 1 && m <= 4) v = t(t(g1, a), x) + t(t(g2, b), y);
    else v = t(g1, a) + t(g2, b);
    v = v + ad;
    return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (e !== s) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task drain;
    n = 0;
    while (eq.size() > 0 && n++ < 300) @(posedge ref_clk);
  endtask
  // Settings change only with the pipe empty, so expectations stay exact
  task cfg(logic [31:0] c, logic [31:0] g1, logic [31:0] g2);
    drain();
    ctrl = c;
    gw1 = g1;
    gw2 = g2;
    apb(1, `OMS_ADDR_CTRL, c);
    apb(1, `OMS_ADDR_GAIN_W1, g1);
    apb(1, `OMS_ADDR_GAIN_W2, g2);
  endtask
  task push(logic [15:0] a, b, c1, c2);
    eq.push_back({wv(ctrl[2:0], gw1, $signed(a), route_both ? $signed(b) : 0, $signed(c1), $signed(c2),
      ctrl[8] ? $signed(c1) : 0), wv(ctrl[6:4], gw2, route_both ? $signed(a) : 0, $signed(b), $signed(c1),
      $signed(c2), ctrl[9] ? $signed(c2) : 0)});
    sent++;
  endtask
  // Released pattern lines show the inverse; carrier lines keep the old value
  task send(logic [15:0] a, b, c1, c2);
    @(posedge ref_clk);
    in_valid <= 1;
    pattern_a <= a;
    pattern_b <= b;
    carrier_a <= c1;
    carrier_b <= c2;
    n = 0;
    do @(posedge ref_clk); while (in_ready !== 1'b1 && ++n < 50);
    in_valid <= 0;
    pattern_a <= ~a;
    pattern_b <= ~b;
    push(a, b, c1, c2);
  endtask
  // Every accepted pair is compared in order
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && dac_ready === 1'b1) begin
      chk("wave", eq.size() ? eq.pop_front() : 32'hX, {wave_out1, wave_out2});
    end
  end
  task conclude;
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    conclude();
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    apb(0, `OMS_ADDR_CTRL, 0);
    chk("ctrl", 0, rd);
    apb(0, `OMS_ADDR_GAIN_W1, 0);
    chk("gain1", `OMS_GAIN_RESET, rd);
    apb(0, `OMS_ADDR_STATUS, 0);
    chk("status", 0, rd);
    apb(1, 8'h10, 32'hFFFFFFFF);
    chk("werr", 1, serr);
    apb(0, 8'h10, 0);
    chk("rerr", 1, serr);
    chk("rdata", 0, rd);
    for (int m = 0; m < 8; m++) begin
      cfg({22'h0, 3'(7 - m), 1'b0, 3'(m)}, 32'h2000_4000, 32'hC000_4000);
      send(16'h2000, 16'h4000, 16'h4000, 16'hC000);
    end
    apb(0, `OMS_ADDR_GAIN_W2, 0);
    chk("gain2", 32'hC000_4000, rd);
    route_both <= 0;
    cfg(0, 32'h4000_4000, 32'h4000_4000);
    send(16'h2000, 16'h4000, 0, 0);
    route_both <= 1;
    cfg(32'h0000_0311, 32'h4000_4000, 32'h2000_2000);
    send(16'h2000, 16'hE000, 16'h2000, 16'hC000);
    cfg(0, 32'h7FFF_7FFF, 32'h7FFF_7FFF);
    send(16'h7FFF, 16'h7FFF, 0, 0);
    send(16'h8000, 16'h8000, 0, 0);
    drain();
    apb(0, `OMS_ADDR_STATUS, 0);
    chk("sat", 3, rd[1:0]);
    apb(1, `OMS_ADDR_STATUS, 3);
    apb(0, `OMS_ADDR_STATUS, 0);
    chk("satclr", 0, rd[1:0]);
    // Correction setup with no imbalance: lambda one half, cosine and sine of one oscillator
    cfg(32'h0000_0055, 32'h0000_4000, 32'h4000_0000);
    send(16'h4000, 16'h2000, 16'h7FFF, 16'h0000);
    send(16'h4000, 16'h2000, 16'h0000, 16'h7FFF);
    send(16'h4000, 16'h2000, 16'h0000, 16'h8001);
    cfg(0, 32'h0000_4000, 32'h4000_0000);
    stall <= 1;
    @(posedge ref_clk);
    in_valid <= 1;
    n = sent;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (in_ready === 1'b1) begin
        push(pattern_a, pattern_b, carrier_a, carrier_b);
        pattern_a <= pattern_a + 16'h0100;
      end
    end
    in_valid <= 0;
    chk("taken", 9, sent - n);
    apb(0, `OMS_ADDR_STATUS, 0);
    chk("level", 8, rd[7:4]);
    stall <= 0;
    slow <= 1;
    drain();
    repeat (4) @(posedge ref_clk);
    chk("left", 0, eq.size());
    chk("count", sent, got);
    conclude();
  end
endmodule
